// file: key_mode_pkg.sv
// constants, types and register map of the electronic mode keyswitch
// assumes a 50 MHz system clock and an AXI4-Lite register master
package key_mode_pkg;

	localparam int unsigned CLK_HZ          = 50_000_000;
	localparam int unsigned TICK_MS         = 1;
	localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
	localparam int unsigned MODE_HOLD_MS    = 500;
	localparam int unsigned STOP_HOLD_MS    = 300;
	localparam int unsigned FLASH_MS        = 200;
	localparam int unsigned FLASH_HALF_MS   = 50;

	localparam logic [7:0] ADDR_CTRL    = 8'h00;
	localparam logic [7:0] ADDR_STATUS  = 8'h04;
	localparam logic [7:0] ADDR_IRQ_ST  = 8'h08;
	localparam logic [7:0] ADDR_IRQ_MSK = 8'h0C;
	localparam logic [7:0] ADDR_OUTIMG  = 8'h10;
	localparam logic [7:0] ADDR_PHYOUT  = 8'h14;

	localparam int unsigned CTRL_CARD_BIT   = 0;
	localparam int unsigned CTRL_CFGDEP_BIT = 1;
	localparam int unsigned IRQ_MODE_BIT    = 0;
	localparam int unsigned IRQ_CLEAR_BIT   = 1;
	localparam int unsigned IRQ_LOSS_BIT    = 2;
	localparam logic [2:0]  IRQ_RESET       = 3'h0;
	localparam logic [1:0]  CTRL_RESET      = 2'h0;
	localparam logic [1:0]  AXI_OKAY        = 2'h0;
	localparam logic [1:0]  AXI_SLVERR      = 2'h2;

	typedef enum logic [3:0] {
		MODE_RUN_PROG = 4'b0001,
		MODE_RUN      = 4'b0010,
		MODE_STOP     = 4'b0100,
		MODE_CLEAR    = 4'b1000
	} cpu_mode_t;

	typedef enum logic [3:0] {
		SEQ_IDLE    = 4'b0001,
		SEQ_ARMED   = 4'b0010,
		SEQ_RELEASE = 4'b0100,
		SEQ_FLASH   = 4'b1000
	} clear_seq_t;

	typedef struct packed {
		logic run_prog;
		logic run;
		logic stop;
		logic clear;
	} key_leds_t;

	typedef struct packed {
		logic execute;
		logic allow_read;
		logic allow_write;
		logic panel_enable;
		logic memory_clear;
		logic reload_from_card;
	} cpu_ctrl_t;

endpackage : key_mode_pkg

// file: key_mode_selector.sv
// electronic mode keyswitch: hold timing, mode leds, memory clear gesture, registers
// assumes key and authorization pins are asynchronous; axi4-lite master on aclk
//
// Local design decisions: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module key_mode_selector #(
	parameter int unsigned OUT_W    = 16,
	parameter int unsigned TICK_LEN = key_mode_pkg::TICK_CYCLES
) (
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	input  wire logic                       key_up,
	input  wire logic                       key_down,
	input  wire logic                       authorize,
	input  wire logic                       card_present,
	input  wire logic [7:0]                 s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [7:0]                 s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic [31:0]                     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	output key_mode_pkg::key_leds_t         key_leds,
	output logic                            cpu_run_led,
	output logic                            cpu_stop_led,
	output key_mode_pkg::cpu_ctrl_t         cpu_ctrl,
	output logic [OUT_W-1:0]                digital_outputs,
	output logic                            irq
);
	import key_mode_pkg::*;

	localparam logic [15:0] TICK_LAST  = 16'(TICK_LEN - 1);
	localparam logic [9:0]  MODE_HOLD  = 10'(MODE_HOLD_MS);
	localparam logic [9:0]  STOP_HOLD  = 10'(STOP_HOLD_MS);
	localparam logic [9:0]  FLASH_LEN  = 10'(FLASH_MS);
	localparam logic [9:0]  FLASH_HALF = 10'(FLASH_HALF_MS);

	////////////////////////////////////////////////////////////////////////////
	// input synchronisers
	logic [3:0] sync_a;
	logic [3:0] sync_b;
	logic       up_s;
	logic       down_s;
	logic       auth_s;
	logic       card_s;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sync_a <= 4'h0;
			sync_b <= 4'h0;
		end
		else
		begin
			sync_a <= {card_present, authorize, key_down, key_up};
			sync_b <= sync_a;
		end
	end
	assign up_s   = sync_b[0];
	assign down_s = sync_b[1];
	assign auth_s = sync_b[2];
	assign card_s = sync_b[3];

	////////////////////////////////////////////////////////////////////////////
	// millisecond tick
	logic [15:0] tick_cnt;
	logic        tick;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			tick_cnt <= 16'h0000;
			tick     <= 1'b0;
		end
		else
		begin
			tick     <= (tick_cnt == TICK_LAST);
			tick_cnt <= (tick_cnt == TICK_LAST) ? 16'h0000 : tick_cnt + 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// hold timing and mode selection
	cpu_mode_t  mode;
	clear_seq_t seq;
	logic [9:0] hold_ms;
	logic       step_done;
	logic       key_any;
	logic       down_only;
	logic       up_only;
	logic [9:0] need_ms;
	logic       mode_evt;
	logic       clear_evt;
	logic [9:0] flash_ms;

	assign key_any   = auth_s && (up_s ^ down_s);
	assign down_only = auth_s && down_s && !up_s;
	assign up_only   = auth_s && up_s && !down_s;
	// reaching stop from run needs the shorter hold
	assign need_ms   = (down_only && mode == MODE_RUN) ? STOP_HOLD : MODE_HOLD;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			hold_ms   <= 10'h000;
			step_done <= 1'b0;
		end
		else if (!key_any)
		begin
			hold_ms   <= 10'h000;
			step_done <= 1'b0;
		end
		else if (tick && !step_done)
		begin
			if (hold_ms + 10'h001 >= need_ms)
			begin
				// continuing down hold from run re-times the next step
				hold_ms   <= 10'h000;
				step_done <= !(down_only && mode == MODE_RUN);
			end
			else
				hold_ms <= hold_ms + 10'h001;
		end
	end

	logic step_now;
	assign step_now = key_any && tick && !step_done && (hold_ms + 10'h001 >= need_ms);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			mode <= MODE_STOP;
		else if (step_now)
		begin
			unique case (mode)
				MODE_RUN_PROG: mode <= down_only ? MODE_RUN : MODE_RUN_PROG;
				MODE_RUN:      mode <= down_only ? MODE_STOP : MODE_RUN_PROG;
				MODE_STOP:     mode <= down_only ? MODE_CLEAR : MODE_RUN;
				MODE_CLEAR:    mode <= down_only ? MODE_CLEAR : MODE_STOP;
			endcase
		end
		else if (seq == SEQ_FLASH && flash_ms == FLASH_LEN)
			mode <= MODE_STOP;
	end
	assign mode_evt = step_now;

	////////////////////////////////////////////////////////////////////////////
	// memory clear gesture: release then press down again
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			seq      <= SEQ_IDLE;
			flash_ms <= 10'h000;
		end
		else
		begin
			unique case (seq)
				SEQ_IDLE:    if (mode == MODE_CLEAR) seq <= SEQ_ARMED;
				SEQ_ARMED:
					if (mode != MODE_CLEAR) seq <= SEQ_IDLE;
					else if (auth_s && !down_s) seq <= SEQ_RELEASE;
				SEQ_RELEASE:
					if (mode != MODE_CLEAR) seq <= SEQ_IDLE;
					else if (down_only)
					begin
						seq      <= SEQ_FLASH;
						flash_ms <= 10'h000;
					end
				SEQ_FLASH:
					if (flash_ms == FLASH_LEN) seq <= SEQ_IDLE;
					else if (tick) flash_ms <= flash_ms + 10'h001;
			endcase
		end
	end
	assign clear_evt = (seq == SEQ_RELEASE) && (mode == MODE_CLEAR) && down_only;

	////////////////////////////////////////////////////////////////////////////
	// leds and cpu control
	logic       running;
	logic       flash_on;
	assign running  = (mode == MODE_RUN_PROG) || (mode == MODE_RUN);
	assign flash_on = (seq == SEQ_FLASH) ? ((flash_ms / FLASH_HALF) % 10'h002 == 10'h000)
	                                     : 1'b1;

	logic [1:0]       ctrl;
	logic [OUT_W-1:0] out_image;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			key_leds     <= '0;
			cpu_run_led  <= 1'b0;
			cpu_stop_led <= 1'b0;
			cpu_ctrl     <= '0;
			digital_outputs <= '0;
		end
		else
		begin
			key_leds.run_prog <= auth_s && mode == MODE_RUN_PROG;
			key_leds.run      <= auth_s && mode == MODE_RUN;
			key_leds.stop     <= auth_s && mode == MODE_STOP;
			key_leds.clear    <= auth_s && mode == MODE_CLEAR;
			cpu_run_led       <= auth_s && running;
			cpu_stop_led      <= auth_s && !running && flash_on;
			cpu_ctrl.execute      <= running;
			cpu_ctrl.allow_read   <= 1'b1;
			cpu_ctrl.allow_write  <= mode != MODE_RUN;
			cpu_ctrl.panel_enable <= 1'b1;
			cpu_ctrl.memory_clear <= clear_evt;
			cpu_ctrl.reload_from_card <= clear_evt && card_s;
			digital_outputs <= running ? out_image : '0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// axi4-lite slave
	logic [2:0]  irq_st;
	logic [2:0]  irq_msk;
	logic [2:0]  irq_set;
	logic [2:0]  irq_clr;
	logic        aw_held;
	logic        w_held;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        do_write;

	assign do_write = aw_held && w_held && !s_axi_bvalid;
	assign irq_set  = {clear_evt && ctrl[CTRL_CFGDEP_BIT], clear_evt, mode_evt};

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= 8'h00;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= AXI_OKAY;
			ctrl      <= CTRL_RESET;
			irq_msk   <= IRQ_RESET;
			out_image <= '0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write)
			begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= AXI_OKAY;
				unique case (aw_addr)
					ADDR_CTRL:    if (w_strb[0]) ctrl <= w_data[1:0];
					ADDR_IRQ_MSK: if (w_strb[0]) irq_msk <= w_data[2:0];
					ADDR_OUTIMG:
						for (int i = 0; i < OUT_W; i++)
							if (w_strb[i/8]) out_image[i] <= w_data[i];
					ADDR_IRQ_ST, ADDR_STATUS, ADDR_PHYOUT: ;
					default: s_axi_bresp <= AXI_SLVERR;
				endcase
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end
	assign s_axi_awready = aresetn && !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = aresetn && !w_held && !s_axi_bvalid;
	assign irq_clr = (do_write && aw_addr == ADDR_IRQ_ST && w_strb[0]) ? w_data[2:0] : 3'h0;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			irq_st <= IRQ_RESET;
			irq    <= 1'b0;
		end
		else
		begin
			irq_st <= (irq_st & ~irq_clr) | irq_set;   // set wins over clear
			irq    <= |(irq_st & irq_msk);
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= AXI_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= AXI_OKAY;
			s_axi_rdata  <= 32'h0000_0000;
			unique case (s_axi_araddr)
				ADDR_CTRL:    s_axi_rdata <= {30'h0, ctrl};
				ADDR_STATUS:  s_axi_rdata <= {22'h0, card_s, auth_s, seq, mode};
				ADDR_IRQ_ST:  s_axi_rdata <= {29'h0, irq_st};
				ADDR_IRQ_MSK: s_axi_rdata <= {29'h0, irq_msk};
				ADDR_OUTIMG:  s_axi_rdata <= 32'(out_image);
				ADDR_PHYOUT:  s_axi_rdata <= 32'(digital_outputs);
				default:      s_axi_rresp <= AXI_SLVERR;
			endcase
		end
		else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end
	assign s_axi_arready = aresetn && !s_axi_rvalid;

endmodule : key_mode_selector

// file: operator_model.sv
// operator model: mode keys, authorization and card pins
// assumes calls arrive just after a rising edge of aclk
`timescale 1ns/1ps
module operator_model (
	input	wire logic	aclk,
	output	logic	key_up,
	output	logic	key_down,
	output	logic	authorize,
	output	logic	card_present
);
	initial
	begin
		{key_up, key_down, authorize, card_present} = 4'h0;
	end
	task automatic set_pins(input logic a, input logic c);
		authorize <= a;
		card_present <= c;
	endtask : set_pins
	// keys pressed for n cycles, then released for one
	task automatic hold(input logic [1:0] k, input int n);
		{key_up, key_down} <= k;
		repeat (n) @(posedge aclk);
		{key_up, key_down} <= 2'h0;
		@(posedge aclk);
	endtask : hold
endmodule : operator_model

// file: key_mode_selector_asserts.sv
// assertion checker for key_mode_selector, attached by bind
// assumes it sees only the top module ports
`timescale 1ns/1ps
module key_mode_selector_asserts #(
	parameter int unsigned OUT_W    = 16,
	parameter int unsigned TICK_LEN = key_mode_pkg::TICK_CYCLES
) (
	input	wire logic	aclk,
	input	wire logic	aresetn,
	input	wire logic	key_up,
	input	wire logic	key_down,
	input	wire logic	authorize,
	input	wire logic	s_axi_bvalid,
	input	wire logic	s_axi_bready,
	input	wire logic [1:0]	s_axi_bresp,
	input	wire logic	s_axi_arvalid,
	input	wire logic	s_axi_arready,
	input	wire logic	s_axi_rvalid,
	input	wire key_mode_pkg::key_leds_t	key_leds,
	input	wire key_mode_pkg::cpu_ctrl_t	cpu_ctrl,
	input	wire logic [OUT_W-1:0]	digital_outputs
);
	import key_mode_pkg::*;
	localparam int unsigned MIN_HOLD = (STOP_HOLD_MS - 1) * TICK_LEN;
	int unsigned	hold_cnt;
	int unsigned	last_hold;
	////////////////////////////////////////////////////////////
	// length of the current single-key hold, kept after release
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !authorize || key_up == key_down)
			hold_cnt <= 0;
		else
			hold_cnt <= hold_cnt + 1;
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			last_hold <= 0;
		else if (hold_cnt != 0)
			last_hold <= hold_cnt;
	end
	////////////////////////////////////////////////////////////
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence s_mode_step;
		key_leds != 4'h0 && $past(key_leds) != 4'h0 && key_leds != $past(key_leds);
	endsequence
	sequence s_not_from_clear;
		!$past(key_leds.clear);
	endsequence
	property p_hold;
		s_mode_step ##0 s_not_from_clear |-> hold_cnt >= MIN_HOLD || last_hold >= MIN_HOLD;
	endproperty
	a_hold: assert property (p_hold)
		else $error("mode step without long hold");
	property p_auth_off;
		!authorize [*5] |-> key_leds == 4'h0;
	endproperty
	a_auth_off: assert property (p_auth_off)
		else $error("mode leds lit without authorization");
	property p_stop_dout;
		!cpu_ctrl.execute [*2] |-> digital_outputs == '0;
	endproperty
	a_stop_dout: assert property (p_stop_dout)
		else $error("outputs driven while halted");
	property p_stop_access;
		key_leds.stop [*3] |-> !cpu_ctrl.execute && cpu_ctrl.allow_read && cpu_ctrl.allow_write
			&& cpu_ctrl.panel_enable;
	endproperty
	a_stop_access: assert property (p_stop_access)
		else $error("wrong access in stop");
	property p_run_ro;
		key_leds.run [*3] |-> cpu_ctrl.execute && cpu_ctrl.allow_read && !cpu_ctrl.allow_write;
	endproperty
	a_run_ro: assert property (p_run_ro)
		else $error("wrong access in run");
	property p_reload;
		cpu_ctrl.reload_from_card |-> cpu_ctrl.memory_clear;
	endproperty
	a_reload: assert property (p_reload)
		else $error("reload without memory clear");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold)
		else $error("write response dropped early");
	property p_r_lat;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_r_lat: assert property (p_r_lat)
		else $error("read data late");
endmodule : key_mode_selector_asserts
bind key_mode_selector key_mode_selector_asserts #(.OUT_W(OUT_W), .TICK_LEN(TICK_LEN))
	i_key_mode_selector_asserts (.*);

// file: tb_top.sv
// self-checking bench for key_mode_selector with an operator model
// assumes full 1 ms ticks are too long to run; 4-cycle ticks instead
`timescale 1ns/1ps
module tb_top;
	import key_mode_pkg::*;
	logic	aclk = 1'b0;
	logic	aresetn = 1'b0;
	logic	key_up, key_down, authorize, card_present, irq, cpu_run_led, cpu_stop_led;
	logic [7:0]	s_axi_awaddr = 8'h00;
	logic [7:0]	s_axi_araddr = 8'h00;
	logic [31:0]	s_axi_wdata = 32'h0;
	logic [3:0]	s_axi_wstrb = 4'hF;
	logic	s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic	s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic	s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]	s_axi_bresp, s_axi_rresp;
	logic [31:0]	s_axi_rdata;
	logic [15:0]	digital_outputs;
	key_leds_t	key_leds;
	cpu_ctrl_t	cpu_ctrl;
	logic [33:0]	exp_q[$];
	int	fails = 0;
	int	cmp_count = 0;
	logic [15:0]	img;
	logic	card;
	int	clr_n = 0;
	int	reload_n = 0;
	int	dark_n = 0;
	int	dark0;
	always #10 aclk = ~aclk;
	// short tick so full holds fit the run
	key_mode_selector #(.OUT_W(16), .TICK_LEN(4)) i_key_mode_selector (.*);
	operator_model i_operator_model (.*);
	////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [33:0] seen, input logic [33:0] expd);
		cmp_count++;
		if (seen !== expd)
		begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", name, expd, seen);
		end
	endtask : check
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		exp_q.push_back({32'h0, r});
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_done && w_done))
		begin
			@(posedge aclk);
			if (!aw_done && s_axi_awready)
			begin
				aw_done = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_done && s_axi_wready)
			begin
				w_done = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask : axi_write
	task automatic axi_read(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		exp_q.push_back({d, r});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask : axi_read
	task automatic complete_run();
		if (fails == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : complete_run
	////////////////////////////////////////////////////////////
	// response monitor: oldest note against each handshake
	always @(posedge aclk)
	begin
		if (s_axi_bvalid && s_axi_bready)
			check("bresp", {32'h0, s_axi_bresp}, exp_q.pop_front());
		else if (s_axi_rvalid && s_axi_rready)
			check("rdata", {s_axi_rdata, s_axi_rresp}, exp_q.pop_front());
	end
	// pulse and flash counters
	always @(posedge aclk)
	begin
		if (cpu_ctrl.memory_clear)
			clr_n++;
		if (cpu_ctrl.reload_from_card)
			reload_n++;
		if (!cpu_stop_led && !cpu_run_led)
			dark_n++;
	end
	initial
	begin
		repeat (40000) @(posedge aclk);
		fails++;
		complete_run();
	end
	initial
	begin
		void'($urandom(32'hd3464d2e));
		card = 1'($urandom);
		img = 16'($urandom);
		@(posedge aclk);
		i_operator_model.set_pins(1'b1, card);
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (8) @(posedge aclk);
		check("key_leds", 34'(key_leds), 34'h2);
		check("cpu_leds", 34'({cpu_run_led, cpu_stop_led}), 34'h1);
		check("cpu_ctrl", 34'(cpu_ctrl), 34'h1C);
		axi_read(ADDR_STATUS, {22'h0, card, 1'b1, 4'h1, 4'h4}, AXI_OKAY);
		axi_write(ADDR_OUTIMG, {16'h0, img}, AXI_OKAY);
		axi_read(ADDR_OUTIMG, {16'h0, img}, AXI_OKAY);
		axi_read(ADDR_PHYOUT, 32'h0, AXI_OKAY);
		check("digital_outputs", 34'(digital_outputs), 34'h0);
		axi_write(ADDR_IRQ_MSK, 32'h7, AXI_OKAY);
		axi_read(ADDR_IRQ_MSK, 32'h7, AXI_OKAY);
		axi_write(ADDR_IRQ_ST, 32'h7, AXI_OKAY);
		axi_read(ADDR_IRQ_ST, 32'h0, AXI_OKAY);
		axi_write(ADDR_STATUS, 32'hF, AXI_OKAY);
		axi_write(8'h20, 32'h1, AXI_SLVERR);
		check("irq", 34'(irq), 34'h0);
		// short presses of each key and of both keys
		for (int k = 1; k < 4; k++)
			i_operator_model.hold(2'(k), 1000);
		repeat (8) @(posedge aclk);
		check("key_leds", 34'(key_leds), 34'h2);
		i_operator_model.set_pins(1'b0, card);
		i_operator_model.hold(2'h1, 2000);
		check("key_leds", 34'(key_leds), 34'h0);
		axi_read(ADDR_STATUS, {22'h0, card, 1'b0, 4'h1, 4'h4}, AXI_OKAY);
		i_operator_model.set_pins(1'b1, card);
		repeat (8) @(posedge aclk);
		check("key_leds", 34'(key_leds), 34'h2);
		// full holds through every mode
		i_operator_model.hold(2'h2, 2100);
		check("key_leds", 34'(key_leds), 34'h4);
		check("cpu_ctrl", 34'(cpu_ctrl), 34'h34);
		check("digital_outputs", 34'(digital_outputs), 34'(img));
		i_operator_model.hold(2'h2, 2100);
		check("key_leds", 34'(key_leds), 34'h8);
		check("cpu_ctrl", 34'(cpu_ctrl), 34'h3C);
		i_operator_model.hold(2'h2, 2100);
		check("key_leds", 34'(key_leds), 34'h8);
		i_operator_model.hold(2'h1, 2100);
		check("key_leds", 34'(key_leds), 34'h4);
		i_operator_model.hold(2'h1, 1400);
		check("key_leds", 34'(key_leds), 34'h2);
		check("cpu_leds", 34'({cpu_run_led, cpu_stop_led}), 34'h1);
		check("digital_outputs", 34'(digital_outputs), 34'h0);
		axi_read(ADDR_OUTIMG, {16'h0, img}, AXI_OKAY);
		i_operator_model.hold(2'h2, 2100);
		i_operator_model.hold(2'h1, 3400);
		check("key_leds", 34'(key_leds), 34'h1);
		axi_read(ADDR_IRQ_ST, 32'h1, AXI_OKAY);
		axi_write(ADDR_CTRL, 32'h2, AXI_OKAY);
		axi_write(ADDR_IRQ_ST, 32'h7, AXI_OKAY);
		// release then brief press runs the memory clear
		dark0 = dark_n;
		i_operator_model.hold(2'h1, 200);
		repeat (900) @(posedge aclk);
		check("key_leds", 34'(key_leds), 34'h2);
		check("cpu_leds", 34'({cpu_run_led, cpu_stop_led}), 34'h1);
		check("stop_flash", 34'(dark_n > dark0), 34'h1);
		check("memory_clear", 34'(clr_n), 34'h1);
		check("reload", 34'(reload_n), 34'(card));
		axi_read(ADDR_IRQ_ST, 32'h6, AXI_OKAY);
		check("irq", 34'(irq), 34'h1);
		complete_run();
	end
endmodule : tb_top
